// [hw/dcr_ctrl_regs.v]
// Operation
// RL1: status code 00 on register 7 drives only servo interrupt to status pin; reset.
// RL2: status code 10 shows decoder status bit or dc offset, picked by shadow.
// RL3: register 7 bit 2 set inverts every sample sent to the dac.
// RL4: register 7 bit 3 set sends right channel first and inverts word clock.
// RL5: register 9 picks pll equalization: nominal, 15 or 30 ns over or under.
// RL6: register A bit 1 picks pre/post concealment audio output; bit 3 adds flags.
// RL7: register A bits 2,0 advertise clock accuracy level II, I or III.
// RL8: register A bits 2,0 both set turn digital output off, held low.
// RL9: register B picks stop standby, pause standby, operation, and single/double speed.
// RL10: register C picks off-track source, kill mode, and drives versatile pin three.
// RL11: mute variant only: register C bit 3 picks soft or hard mute.
// RL12: writes are address plus data nibble; unlisted data codes are reserved, ignored.
`timescale 1ns/1ps
`include "dcr_regs.vh"

module dcr_ctrl_regs #(
  parameter MUTE_VARIANT = 0
) (
  // clock and reset
  input  wire                        mclk,
  input  wire                        reset,
  // register write port from the control interface
  input  wire                        wr_en,
  input  wire [3:0]                  wr_addr,
  input  wire [3:0]                  wr_data,
  output reg                         wr_reserved,
  // status pin sources
  input  wire                        servo_irq,
  input  wire                        decoder_status_bit,
  input  wire                        dc_offset_info,
  input  wire                        shadow_dc_select,
  output reg                         status_pin,
  // dac sample path
  input  wire                        sample_load,
  input  wire [`DCR_SAMPLE_W-1:0]    sample_left,
  input  wire [`DCR_SAMPLE_W-1:0]    sample_right,
  input  wire                        wclk_in,
  output reg                         dac_valid,
  output reg  [`DCR_SAMPLE_W-1:0]    dac_first_word,
  output reg  [`DCR_SAMPLE_W-1:0]    dac_second_word,
  output reg                         dac_wclk,
  // pll equalization
  output reg  [3:0]                  pll_eq_code,
  // digital audio output
  input  wire                        ebu_serial_in,
  output reg                         ebu_after_conceal,
  output reg                         ebu_flags_on,
  output reg  [1:0]                  ebu_accuracy,
  output reg                         ebu_enable,
  output reg                         ebu_serial_out,
  // operating state and speed
  output reg                         stop_standby,
  output reg                         pause_standby,
  output reg                         operating,
  output reg                         double_speed,
  // versatile pins, kill and mute
  input  wire                        versatile_pin_one,
  input  wire                        internal_off_track,
  output reg                         off_track,
  output reg                         versatile_pin_one_status,
  output reg                         versatile_pin_three,
  output reg                         kill_mono,
  output reg                         mute_hard
);

  // register storage
  reg  [3:0] status_pin_and_dac_format;
  reg  [3:0] pll_equalization;
  reg  [3:0] digital_audio_out_config;
  reg  [3:0] speed_and_standby_control;
  reg  [3:0] aux_pins_kill_and_mute;

  reg        code_ok;
  wire       pin_one_sync;

  // synchronise the versatile pin one level
  dcr_sync2 #(
    .WIDTH (1)
  ) u_pin_one_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (versatile_pin_one),
    .sync_out (pin_one_sync)
  );

  // check the data code against the listed codes of each register
  always @* begin
    code_ok = 1'b1;
    case (wr_addr)
      `DCR_ADDR_STATUS_DAC: begin
        code_ok = (wr_data[1:0] == `DCR_STAT_SRC_SERVO) ||
                  (wr_data[1:0] == `DCR_STAT_SRC_DECODER); // RL12
      end
      `DCR_ADDR_PLL_EQ: begin
        code_ok = (wr_data >= `DCR_EQ_OVER_30) && (wr_data <= `DCR_EQ_UNDER_30); // RL12
      end
      `DCR_ADDR_EBU_CFG: begin
        code_ok = 1'b1; // every code is listed
      end
      `DCR_ADDR_SPEED: begin
        code_ok = ((wr_data[2:0] == `DCR_OP_STOP_STANDBY) ||
                   (wr_data[2:0] == `DCR_OP_PAUSE_STANDBY) ||
                   (wr_data[2:0] == `DCR_OP_RUN)) &&
                  ((wr_data[3:2] == `DCR_SPD_SINGLE) ||
                   (wr_data[3:2] == `DCR_SPD_DOUBLE)); // RL12
      end
      `DCR_ADDR_AUX: begin
        // without the mute variant bit 3 has no function and must be 0
        code_ok = (MUTE_VARIANT != 0) || !wr_data[3]; // RL12
      end
      default: begin
        code_ok = 1'b0; // not in this bank
      end
    endcase
  end

  // register writes; reserved codes leave the register unchanged
  always @(posedge mclk) begin
    if (reset) begin
      status_pin_and_dac_format <= `DCR_RST_STATUS_DAC; // RL1
      pll_equalization          <= `DCR_RST_PLL_EQ;
      digital_audio_out_config  <= `DCR_RST_EBU_CFG;
      speed_and_standby_control <= `DCR_RST_SPEED;
      aux_pins_kill_and_mute    <= `DCR_RST_AUX;
      wr_reserved               <= 1'b0;
    end else begin
      wr_reserved <= 1'b0;
      if (wr_en) begin
        if (!code_ok) begin
          case (wr_addr)
            `DCR_ADDR_STATUS_DAC, `DCR_ADDR_PLL_EQ, `DCR_ADDR_SPEED,
            `DCR_ADDR_AUX: begin
              wr_reserved <= 1'b1; // RL12
            end
            default: begin
              wr_reserved <= 1'b0; // other banks decode it
            end
          endcase
        end else begin
          case (wr_addr)
            `DCR_ADDR_STATUS_DAC: status_pin_and_dac_format <= wr_data;
            `DCR_ADDR_PLL_EQ:     pll_equalization          <= wr_data; // RL5
            `DCR_ADDR_EBU_CFG:    digital_audio_out_config  <= wr_data;
            `DCR_ADDR_SPEED:      speed_and_standby_control <= wr_data; // RL9
            `DCR_ADDR_AUX:        aux_pins_kill_and_mute    <= wr_data;
            default: begin
              pll_equalization <= pll_equalization;
            end
          endcase
        end
      end
    end
  end

  // status pin source select
  always @(posedge mclk) begin
    if (reset) begin
      status_pin <= 1'b0;
    end else if (status_pin_and_dac_format[1:0] == `DCR_STAT_SRC_DECODER) begin
      status_pin <= shadow_dc_select ? dc_offset_info : decoder_status_bit; // RL2
    end else begin
      status_pin <= servo_irq; // RL1
    end
  end

  // dac sample path: polarity and channel order
  always @(posedge mclk) begin
    if (reset) begin
      dac_valid       <= 1'b0;
      dac_first_word  <= {`DCR_SAMPLE_W{1'b0}};
      dac_second_word <= {`DCR_SAMPLE_W{1'b0}};
      dac_wclk        <= 1'b0;
    end else begin
      dac_valid <= sample_load;
      dac_wclk  <= wclk_in ^ status_pin_and_dac_format[`DCR_BIT_DAC_SWAP]; // RL4
      if (sample_load) begin
        if (status_pin_and_dac_format[`DCR_BIT_DAC_SWAP]) begin
          dac_first_word  <= status_pin_and_dac_format[`DCR_BIT_DAC_INVERT] ?
                             ~sample_right : sample_right; // RL3 RL4
          dac_second_word <= status_pin_and_dac_format[`DCR_BIT_DAC_INVERT] ?
                             ~sample_left : sample_left; // RL3
        end else begin
          dac_first_word  <= status_pin_and_dac_format[`DCR_BIT_DAC_INVERT] ?
                             ~sample_left : sample_left; // RL3 RL4
          dac_second_word <= status_pin_and_dac_format[`DCR_BIT_DAC_INVERT] ?
                             ~sample_right : sample_right; // RL3
        end
      end
    end
  end

  // pll equalization code to the data slicer
  always @(posedge mclk) begin
    if (reset) begin
      pll_eq_code <= `DCR_RST_PLL_EQ;
    end else begin
      pll_eq_code <= pll_equalization; // RL5
    end
  end

  // digital audio output configuration and gating
  always @(posedge mclk) begin
    if (reset) begin
      ebu_after_conceal <= 1'b1;
      ebu_flags_on      <= 1'b0;
      ebu_accuracy      <= `DCR_ACC_LEVEL_II;
      ebu_enable        <= 1'b1;
      ebu_serial_out    <= 1'b0;
    end else begin
      ebu_after_conceal <= digital_audio_out_config[`DCR_BIT_EBU_AFTER]; // RL6
      ebu_flags_on      <= digital_audio_out_config[`DCR_BIT_EBU_FLAGS]; // RL6
      ebu_accuracy      <= {digital_audio_out_config[`DCR_BIT_EBU_ACC_HI],
                            digital_audio_out_config[`DCR_BIT_EBU_ACC_LO]}; // RL7
      if ({digital_audio_out_config[`DCR_BIT_EBU_ACC_HI],
           digital_audio_out_config[`DCR_BIT_EBU_ACC_LO]} == `DCR_ACC_OFF) begin
        ebu_enable     <= 1'b0; // RL8
        ebu_serial_out <= 1'b0; // RL8
      end else begin
        ebu_enable     <= 1'b1;
        ebu_serial_out <= ebu_serial_in;
      end
    end
  end

  // operating state and speed decode
  always @(posedge mclk) begin
    if (reset) begin
      stop_standby  <= 1'b1;
      pause_standby <= 1'b0;
      operating     <= 1'b0;
      double_speed  <= 1'b0;
    end else begin
      stop_standby  <= (speed_and_standby_control[2:0] == `DCR_OP_STOP_STANDBY); // RL9
      pause_standby <= (speed_and_standby_control[2:0] == `DCR_OP_PAUSE_STANDBY); // RL9
      operating     <= (speed_and_standby_control[2:0] == `DCR_OP_RUN); // RL9
      double_speed  <= (speed_and_standby_control[3:2] == `DCR_SPD_DOUBLE); // RL9
    end
  end

  // versatile pins, kill and mute type
  always @(posedge mclk) begin
    if (reset) begin
      off_track                <= 1'b0;
      versatile_pin_one_status <= 1'b0;
      versatile_pin_three      <= 1'b0;
      kill_mono                <= 1'b1;
      mute_hard                <= 1'b0;
    end else begin
      if (aux_pins_kill_and_mute[`DCR_BIT_OFFTRK_EXT]) begin
        off_track                <= pin_one_sync; // RL10
        versatile_pin_one_status <= 1'b0;
      end else begin
        off_track                <= internal_off_track; // RL10
        versatile_pin_one_status <= pin_one_sync; // RL10
      end
      kill_mono           <= aux_pins_kill_and_mute[`DCR_BIT_KILL_MONO]; // RL10
      versatile_pin_three <= aux_pins_kill_and_mute[`DCR_BIT_PIN3_LEVEL]; // RL10
      if (MUTE_VARIANT != 0) begin
        mute_hard <= aux_pins_kill_and_mute[`DCR_BIT_MUTE_HARD]; // RL11
      end else begin
        mute_hard <= 1'b0;
      end
    end
  end

endmodule

// [hw/dcr_regs.vh]
`ifndef DCR_REGS_VH
`define DCR_REGS_VH

// register addresses (4-bit address nibble)
`define DCR_ADDR_STATUS_DAC   4'h7
`define DCR_ADDR_PLL_EQ       4'h9
`define DCR_ADDR_EBU_CFG      4'ha
`define DCR_ADDR_SPEED        4'hb
`define DCR_ADDR_AUX          4'hc

// reset values
`define DCR_RST_STATUS_DAC    4'h0
`define DCR_RST_PLL_EQ        4'h3
`define DCR_RST_EBU_CFG       4'h2
`define DCR_RST_SPEED         4'h0
`define DCR_RST_AUX           4'h2

// status pin and dac format fields
`define DCR_STAT_SRC_SERVO    2'h0
`define DCR_STAT_SRC_DECODER  2'h2
`define DCR_BIT_DAC_INVERT    2
`define DCR_BIT_DAC_SWAP      3

// pll equalization codes
`define DCR_EQ_OVER_30        4'h1
`define DCR_EQ_OVER_15        4'h2
`define DCR_EQ_NOMINAL        4'h3
`define DCR_EQ_UNDER_15       4'h4
`define DCR_EQ_UNDER_30       4'h5

// digital audio output fields
`define DCR_BIT_EBU_ACC_LO    0
`define DCR_BIT_EBU_AFTER     1
`define DCR_BIT_EBU_ACC_HI    2
`define DCR_BIT_EBU_FLAGS     3
`define DCR_ACC_LEVEL_II      2'h0
`define DCR_ACC_LEVEL_I       2'h1
`define DCR_ACC_LEVEL_III     2'h2
`define DCR_ACC_OFF           2'h3

// operating state and speed codes
`define DCR_OP_STOP_STANDBY   3'h0
`define DCR_OP_PAUSE_STANDBY  3'h2
`define DCR_OP_RUN            3'h3
`define DCR_SPD_SINGLE        2'h0
`define DCR_SPD_DOUBLE        2'h2

// aux pins, kill and mute fields
`define DCR_BIT_OFFTRK_EXT    0
`define DCR_BIT_KILL_MONO     1
`define DCR_BIT_PIN3_LEVEL    2
`define DCR_BIT_MUTE_HARD     3

// audio sample width
`define DCR_SAMPLE_W          18

`endif

// [hw/dcr_sync2.v]
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module dcr_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk,
  input  wire             reset,
  // async level in, synchronised level out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second
  always @(posedge mclk) begin
    if (reset) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [testbench/dcr_ctrl_regs_properties.sv]
`timescale 1ns/1ps
// timing checks on the register write port and the decoded outputs
module dcr_ctrl_regs_properties (
  // clock and reset
  input wire       mclk,
  input wire       reset,
  // write port
  input wire       wr_en,
  input wire [3:0] wr_addr,
  input wire [3:0] wr_data,
  input wire       wr_reserved,
  // observed pins
  input wire       servo_irq,
  input wire       status_pin,
  input wire [3:0] pll_eq_code,
  input wire       ebu_after_conceal,
  input wire       ebu_flags_on,
  input wire [1:0] ebu_accuracy,
  input wire       ebu_enable,
  input wire       ebu_serial_out,
  input wire       stop_standby,
  input wire       operating,
  input wire       double_speed,
  input wire       versatile_pin_three,
  input wire       kill_mono
);
  reg [3:0] d1;
  reg [3:0] d2;
  // data nibble two cycles back, lined up with the output update
  always @(posedge mclk) begin
    d1 <= wr_data;
    d2 <= d1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_status;
    wr_en && wr_addr == 4'h7 && wr_data[1:0] == 2'h0 |-> ##2 status_pin == $past(servo_irq);
  endproperty
  a_status: assert property (p_status) else $error("status pin not servo");
  property p_pll;
    wr_en && wr_addr == 4'h9 && wr_data inside {[4'h1:4'h5]} |-> ##2 pll_eq_code == d2;
  endproperty
  a_pll: assert property (p_pll) else $error("pll code wrong");
  property p_ebu_cfg;
    wr_en && wr_addr == 4'ha && !(wr_data[2] && wr_data[0]) |-> ##2
      ebu_after_conceal == d2[1] && ebu_flags_on == d2[3] && ebu_accuracy == {d2[2], d2[0]};
  endproperty
  a_ebu_cfg: assert property (p_ebu_cfg) else $error("ebu config wrong");
  property p_ebu_off;
    wr_en && wr_addr == 4'ha && wr_data[2] && wr_data[0] |-> ##2 !ebu_enable && !ebu_serial_out;
  endproperty
  a_ebu_off: assert property (p_ebu_off) else $error("ebu not off");
  property p_run;
    wr_en && wr_addr == 4'hb && wr_data[2:0] == 3'h3 |-> ##2 operating && !stop_standby;
  endproperty
  a_run: assert property (p_run) else $error("not operating");
  property p_stop;
    wr_en && wr_addr == 4'hb && wr_data == 4'h0 |-> ##2 stop_standby && !operating && !double_speed;
  endproperty
  a_stop: assert property (p_stop) else $error("not stop standby");
  property p_aux;
    wr_en && wr_addr == 4'hc && !wr_data[3] |-> ##2
      versatile_pin_three == d2[2] && kill_mono == d2[1];
  endproperty
  a_aux: assert property (p_aux) else $error("aux pins wrong");
  property p_rsv;
    wr_en && ((wr_addr == 4'h9 && !(wr_data inside {[4'h1:4'h5]}))
      || (wr_addr == 4'hb && (wr_data[2] || wr_data[1:0] == 2'h1))) |=> wr_reserved;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved not flagged");
  c_run: cover property ($rose(operating));
  c_rsv: cover property (wr_reserved);
  c_off: cover property ($fell(ebu_enable));
endmodule
bind dcr_ctrl_regs dcr_ctrl_regs_properties i_dcr_ctrl_regs_properties (
  .mclk                (mclk),
  .reset               (reset),
  .wr_en               (wr_en),
  .wr_addr             (wr_addr),
  .wr_data             (wr_data),
  .wr_reserved         (wr_reserved),
  .servo_irq           (servo_irq),
  .status_pin          (status_pin),
  .pll_eq_code         (pll_eq_code),
  .ebu_after_conceal   (ebu_after_conceal),
  .ebu_flags_on        (ebu_flags_on),
  .ebu_accuracy        (ebu_accuracy),
  .ebu_enable          (ebu_enable),
  .ebu_serial_out      (ebu_serial_out),
  .stop_standby        (stop_standby),
  .operating           (operating),
  .double_speed        (double_speed),
  .versatile_pin_three (versatile_pin_three),
  .kill_mono           (kill_mono)
);

// [testbench/dcr_host_model.sv]
`timescale 1ns/1ps
// host writer: one address and one data nibble per strobe
module dcr_host_model (
  // clock
  input  wire       mclk,
  // write port
  output reg        wr_en,
  output reg  [3:0] wr_addr,
  output reg  [3:0] wr_data
);
  // idle bus at time zero
  initial begin
    wr_en = 1'h0;
    wr_addr = 4'h0;
    wr_data = 4'h0;
  end
  // strobe held one edge, then the nibbles go to their inverse
  task write(input [3:0] a, input [3:0] d);
    begin
      @(posedge mclk);
      wr_en <= 1'h1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_en <= 1'h0;
      wr_addr <= ~a;
      wr_data <= ~d;
    end
  endtask
endmodule

// [testbench/tb_decoder_control_regs_7_to_c.sv]
`timescale 1ns/1ps
module tb_decoder_control_regs_7_to_c;
  reg         mclk, reset, servo_irq, decoder_status_bit, dc_offset_info, shadow_dc_select;
  reg         sample_load, wclk_in, ebu_serial_in, versatile_pin_one, internal_off_track;
  reg  [17:0] sample_left, sample_right;
  wire        wr_en, wr_reserved, status_pin, dac_valid, dac_wclk, ebu_after_conceal;
  wire [3:0]  wr_addr, wr_data, pll_eq_code;
  wire [17:0] dac_first_word, dac_second_word;
  wire [1:0]  ebu_accuracy;
  wire        ebu_flags_on, ebu_enable, ebu_serial_out, stop_standby, pause_standby;
  wire        operating, double_speed, off_track, versatile_pin_one_status;
  wire        versatile_pin_three, kill_mono, mute_hard;
  integer     mismatches, check_count, i;
  dcr_ctrl_regs i_dcr_ctrl_regs (
    .mclk                     (mclk),
    .reset                    (reset),
    .wr_en                    (wr_en),
    .wr_addr                  (wr_addr),
    .wr_data                  (wr_data),
    .wr_reserved              (wr_reserved),
    .servo_irq                (servo_irq),
    .decoder_status_bit       (decoder_status_bit),
    .dc_offset_info           (dc_offset_info),
    .shadow_dc_select         (shadow_dc_select),
    .status_pin               (status_pin),
    .sample_load              (sample_load),
    .sample_left              (sample_left),
    .sample_right             (sample_right),
    .wclk_in                  (wclk_in),
    .dac_valid                (dac_valid),
    .dac_first_word           (dac_first_word),
    .dac_second_word          (dac_second_word),
    .dac_wclk                 (dac_wclk),
    .pll_eq_code              (pll_eq_code),
    .ebu_serial_in            (ebu_serial_in),
    .ebu_after_conceal        (ebu_after_conceal),
    .ebu_flags_on             (ebu_flags_on),
    .ebu_accuracy             (ebu_accuracy),
    .ebu_enable               (ebu_enable),
    .ebu_serial_out           (ebu_serial_out),
    .stop_standby             (stop_standby),
    .pause_standby            (pause_standby),
    .operating                (operating),
    .double_speed             (double_speed),
    .versatile_pin_one        (versatile_pin_one),
    .internal_off_track       (internal_off_track),
    .off_track                (off_track),
    .versatile_pin_one_status (versatile_pin_one_status),
    .versatile_pin_three      (versatile_pin_three),
    .kill_mono                (kill_mono),
    .mute_hard                (mute_hard)
  );
  dcr_host_model i_dcr_host_model (
    .mclk    (mclk),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data)
  );
  // free-running clock
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // write, then let the derived outputs settle
  task wr(input [3:0] a, input [3:0] d);
    begin
      i_dcr_host_model.write(a, d);
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask
  // write an unlisted code and expect the flag pulse
  task rsv(input [3:0] a, input [3:0] d);
    begin
      i_dcr_host_model.write(a, d);
      #1;
      chk("reserved", wr_reserved, 1'h1);
      @(posedge mclk);
      #1;
    end
  endtask
  task t_status;
    begin
      @(posedge mclk);
      {servo_irq, decoder_status_bit} <= 2'h2;
      wr(4'h7, 4'h0);
      chk("stat_servo", status_pin, 1'h1);
      @(posedge mclk);
      servo_irq <= 1'h0;
      decoder_status_bit <= 1'h1;
      wr(4'h7, 4'h2);
      chk("stat_dec", status_pin, 1'h1);
      @(posedge mclk);
      shadow_dc_select <= 1'h1;
      repeat (2) @(posedge mclk);
      #1;
      chk("stat_dc", status_pin, 1'h0);
    end
  endtask
  // one sample pair, looked at while dac_valid stands
  task load(input [17:0] l, input [17:0] r);
    begin
      @(posedge mclk);
      {sample_load, sample_left, sample_right} <= {1'h1, l, r};
      @(posedge mclk);
      sample_load <= 1'h0;
      #1;
      chk("valid", dac_valid, 1'h1);
    end
  endtask
  task t_dac;
    begin
      wr(4'h7, 4'hc);
      load(18'h00001, 18'h00002);
      chk("first", dac_first_word, ~18'h00002);
      chk("second", dac_second_word, ~18'h00001);
      chk("wclk", dac_wclk, 1'h1);
      @(posedge mclk);
      #1;
      chk("valid_end", dac_valid, 1'h0);
      wr(4'h7, 4'h4);
      load(18'h00003, 18'h00004);
      chk("inv_first", dac_first_word, ~18'h00003);
      chk("inv_wclk", dac_wclk, 1'h0);
      wr(4'h7, 4'h0);
      load(18'h00005, 18'h00006);
      chk("norm_first", dac_first_word, 18'h00005);
      chk("norm_second", dac_second_word, 18'h00006);
    end
  endtask
  task t_pll;
    begin
      for (i = 1; i < 6; i = i + 1) begin
        wr(4'h9, i[3:0]);
        chk("pll", pll_eq_code, i[3:0]);
      end
      rsv(4'h9, 4'h0);
      rsv(4'h9, 4'h6);
      chk("pll_kept", pll_eq_code, 4'h5);
    end
  endtask
  task t_ebu;
    begin
      @(posedge mclk);
      ebu_serial_in <= 1'h1;
      wr(4'ha, 4'h9);
      chk("after", ebu_after_conceal, 1'h0);
      chk("flags", ebu_flags_on, 1'h1);
      chk("acc_i", ebu_accuracy, 2'h1);
      chk("ser", ebu_serial_out, 1'h1);
      wr(4'ha, 4'h4);
      chk("acc_iii", ebu_accuracy, 2'h2);
      wr(4'ha, 4'h5);
      chk("enable", ebu_enable, 1'h0);
      chk("ser_off", ebu_serial_out, 1'h0);
    end
  endtask
  task t_speed;
    begin
      wr(4'hb, 4'h2);
      chk("pause", pause_standby, 1'h1);
      wr(4'hb, 4'hb);
      chk("run", {stop_standby, operating, double_speed}, 3'h3);
      rsv(4'hb, 4'h1);
      rsv(4'hb, 4'h7);
      chk("run_kept", operating, 1'h1);
      wr(4'hb, 4'h0);
      chk("stop", {stop_standby, pause_standby, operating, double_speed}, 4'h8);
    end
  endtask
  task t_aux;
    begin
      @(posedge mclk);
      versatile_pin_one <= 1'h1;
      wr(4'hc, 4'h5);
      chk("ext_trk", {off_track, versatile_pin_one_status}, 2'h2);
      chk("pins", {versatile_pin_three, kill_mono}, 2'h2);
      wr(4'hc, 4'h0);
      chk("int_trk", {off_track, versatile_pin_one_status}, 2'h1);
      rsv(4'hc, 4'h8);
      chk("mute", mute_hard, 1'h0);
    end
  endtask
  task wrap_up;
    begin
      if (mismatches == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // reset, reset values, then every scenario
  initial begin
    mismatches = 0;
    check_count = 0;
    reset = 1'h1;
    {servo_irq, decoder_status_bit, dc_offset_info, shadow_dc_select} = 4'h0;
    {sample_load, wclk_in, ebu_serial_in, versatile_pin_one, internal_off_track} = 5'h0;
    {sample_left, sample_right} = 36'h0;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    #1;
    chk("rst_pll", pll_eq_code, 4'h3);
    chk("rst_ebu", {ebu_after_conceal, ebu_accuracy, ebu_enable}, 4'h9);
    chk("rst_b", {stop_standby, operating}, 2'h2);
    chk("rst_c", {kill_mono, versatile_pin_three, mute_hard}, 3'h4);
    t_status;
    t_dac;
    t_pll;
    t_ebu;
    t_speed;
    t_aux;
    wrap_up;
  end
  // hang guard
  initial begin
    #100000;
    mismatches = mismatches + 1;
    wrap_up;
  end
endmodule
